// ---- tb_tpc_supervisor.sv ----
// Self-checking bench for the supervisor
`timescale 1ns/1ps
module tb_tpc_supervisor;
    import tpc_pkg::*;
    logic i_clk, i_nrst, i_sclk, i_cs_n, i_si, o_so, o_int_n_o, o_int_n_oe;
    logic i_temp_warm_trip, i_temp_warm_hold, i_temp_hot_trip, i_temp_hot_hold;
    logic i_warm_derate_off_source, i_warm_derate_off_sink, i_event_read;
    logic i_checksum_trigger, i_checksum_done_irq_enable, i_switch_change;
    logic i_poll_cycle_done, o_rx_valid, o_poll_restart, o_store_default;
    logic o_warm_status, o_overheat_status, o_thermal_spi_flag, o_sources_open;
    logic o_checksum_trigger_clr, o_checksum_busy;
    tpc_wc_t [23:0] i_wc_cfg, o_wc_eff;
    logic [175:0]   i_cfg_image;
    logic [29:0]    i_tx_payload;
    logic [31:0]    o_rx_word, w;
    logic [15:0]    o_checksum_result;
    logic [4:0]     o_event_status;
    logic [31:0]    exp_q[$];
    int             mismatches, num_checks, seed, n, pr, sd;

    tpc_supervisor tpc_supervisor_inst (
        .i_clk, .i_nrst, .i_sclk, .i_cs_n, .i_si, .o_so, .o_int_n_o, .o_int_n_oe,
        .i_temp_warm_trip, .i_temp_warm_hold, .i_temp_hot_trip, .i_temp_hot_hold,
        .i_warm_derate_off_source, .i_warm_derate_off_sink, .i_wc_cfg, .i_checksum_trigger,
        .i_checksum_done_irq_enable, .i_cfg_image, .i_event_read, .i_tx_payload, .o_rx_word,
        .o_rx_valid, .i_switch_change, .i_poll_cycle_done, .o_poll_restart, .o_store_default,
        .o_event_status, .o_warm_status, .o_overheat_status, .o_thermal_spi_flag, .o_wc_eff,
        .o_sources_open, .o_checksum_result, .o_checksum_trigger_clr, .o_checksum_busy);
    tpc_host_model tpc_host_model_inst (
        .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_si(i_si), .i_so(o_so));

    // 200 MHz core clock
    initial i_clk = 1'b0;
    always #2.5 i_clk = ~i_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wait_cyc(input int k);
        repeat (k) @(negedge i_clk);
    endtask : wait_cyc

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // Reference checksum, trigger bit counted as one
    function automatic logic [15:0] crc_of(input logic [175:0] img);
        logic [15:0] c;
        img[161] = 1'b1;
        c = 16'hFFFF;
        for (int i = 175; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ img[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction : crc_of

    // Frame with optional status read while chip select is low
    task automatic frame(input logic [31:0] f, input logic rd);
        fork
            tpc_host_model_inst.xfer(f);
            if (rd) begin
                wait_cyc(20);
                i_event_read = 1'b1;
                wait_cyc(1);
                i_event_read = 1'b0;
            end
        join
        wait_cyc(8);
    endtask : frame

    task automatic good(input logic rd);
        w = $random(seed);
        w[0] = ~^w[31:1];
        exp_q.push_back(w);
        frame(w, rd);
        chk(^tpc_host_model_inst.rx_so, 1);
    endtask : good

    // Expected currents: off in shutdown, 10/15 mA derated to 2 mA
    task automatic chk_wc(input logic der, input logic off);
        for (int i = 0; i < 24; i++)
            chk(o_wc_eff[i], off ? 0 : (der && i_wc_cfg[i] >= 3'h4) ? 2 : i_wc_cfg[i]);
    endtask : chk_wc

    // Result pulses retire the oldest note; also count polling pulses
    always @(negedge i_clk) begin
        if (o_rx_valid === 1'b1 || o_checksum_trigger_clr === 1'b1) begin
            if (exp_q.size() == 0) chk(1, 0);
            else chk(o_rx_valid ? o_rx_word : {16'h0000, o_checksum_result}, exp_q.pop_front());
        end
        pr += o_poll_restart;
        sd += o_store_default;
    end

    // Hang guard
    initial begin
        #400000;
        mismatches++;
        finish_test();
    end

    initial begin
        seed = 32'h949EE65A;
        {i_nrst, i_temp_warm_trip, i_temp_warm_hold, i_temp_hot_trip, i_temp_hot_hold} = '0;
        {i_warm_derate_off_source, i_warm_derate_off_sink, i_event_read, i_switch_change} = '0;
        {i_checksum_trigger, i_checksum_done_irq_enable, i_poll_cycle_done} = '0;
        i_wc_cfg = '0;
        i_cfg_image = '0;
        i_tx_payload = 30'($random(seed));
        wait_cyc(6);
        i_nrst = 1'b1;
        wait_cyc(6);
        // Checksum with completion interrupt masked, then enabled
        for (int e = 0; e < 2; e++) begin
            for (int k = 0; k < 6; k++) i_cfg_image = {i_cfg_image[143:0], 32'($random(seed))};
            i_checksum_done_irq_enable = e[0];
            exp_q.push_back({16'h0000, crc_of(i_cfg_image)});
            i_checksum_trigger = 1'b1;
            wait_cyc(2);
            chk(o_checksum_busy, 1);
            for (n = 0; n < 300 && o_checksum_trigger_clr !== 1'b1; n++) @(negedge i_clk);
            i_checksum_trigger = 1'b0;
            wait_cyc(2);
            chk({n < 300, o_event_status[4], o_checksum_busy, o_int_n_o}, 4'hC);
            chk(o_int_n_oe, e);
            good(1'b1);
            chk({o_int_n_oe, o_event_status}, 0);
        end
        $display("checksum and frame test done");
        // Even-parity frame is dropped; unread status survives a frame
        w = $random(seed);
        w[0] = ^w[31:1];
        frame(w, 1'b0);
        chk({o_int_n_oe, o_event_status[3], ^o_rx_word}, 3'h7);
        good(1'b0);
        chk(o_event_status[3], 1);
        good(1'b1);
        $display("parity test done");
        // Warning entry, derating, hold and disable
        for (int i = 0; i < 24; i++) i_wc_cfg[i] = 3'($unsigned($random(seed)) % 6);
        i_temp_warm_trip = 1'b1;
        i_temp_warm_hold = 1'b1;
        wait_cyc(6);
        chk({o_warm_status, o_event_status, o_int_n_oe, o_thermal_spi_flag}, 8'h87);
        chk_wc(1'b1, 1'b0);
        i_temp_warm_trip = 1'b0;
        good(1'b1);
        chk(tpc_host_model_inst.rx_so[31], 1);
        chk(tpc_host_model_inst.rx_so[29:1], i_tx_payload[28:0]);
        wait_cyc(20);
        chk({o_warm_status, o_event_status, o_int_n_oe}, 7'h40);
        chk_wc(1'b1, 1'b0);
        i_warm_derate_off_sink = 1'b1;
        wait_cyc(6);
        chk_wc(1'b0, 1'b0);
        i_warm_derate_off_sink = 1'b0;
        // Shutdown entry, hold and exit
        i_temp_hot_trip = 1'b1;
        i_temp_hot_hold = 1'b1;
        wait_cyc(6);
        chk({o_sources_open, o_overheat_status, o_warm_status, o_event_status, o_int_n_oe},
            9'h1C5);
        chk_wc(1'b0, 1'b1);
        good(1'b1);
        i_temp_hot_trip = 1'b0;
        wait_cyc(20);
        chk({o_sources_open, o_event_status}, 6'h20);
        i_temp_hot_hold = 1'b0;
        wait_cyc(6);
        chk({o_sources_open, o_overheat_status, o_warm_status, o_event_status, o_int_n_oe},
            9'h045);
        chk_wc(1'b1, 1'b0);
        i_poll_cycle_done = 1'b1;
        wait_cyc(1);
        i_poll_cycle_done = 1'b0;
        wait_cyc(6);
        chk({pr * 4 + sd, o_event_status[2]}, 11);
        good(1'b1);
        i_temp_warm_hold = 1'b0;
        wait_cyc(6);
        chk({o_warm_status, o_event_status[0], o_int_n_oe}, 3'h3);
        chk_wc(1'b0, 1'b0);
        $display("thermal test done");
        wait_cyc(10);
        chk(exp_q.size(), 0);
        finish_test();
    end
endmodule : tb_tpc_supervisor

// ---- tpc_host_model.sv ----
// Host side of the serial link, driving whole frames
`timescale 1ns/1ps
module tpc_host_model (
    // Link pins
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_si,
    input  wire logic i_so
);
    logic [31:0] rx_so;

    // Clock parked low between frames
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si   = 1'b0;
    end

    // One frame, MSB first, data set up in the low phase
    task automatic xfer(input logic [31:0] w);
        o_cs_n = 1'b0;
        #24;
        for (int i = 31; i >= 0; i--) begin
            o_si = w[i];
            #24 rx_so[i] = i_so;
            o_sclk = 1'b1;
            #24 o_sclk = 1'b0;
        end
        #24 o_cs_n = 1'b1;
        o_si = ~o_si; // Stale bit inverted once released
        #40;
    endtask : xfer
endmodule : tpc_host_model

// ---- tpc_pkg.sv ----
// Types shared by the supervisor
package tpc_pkg;
    typedef logic [2:0] tpc_wc_t;
    typedef enum logic [1:0] {
        TPC_CRC_IDLE = 2'b00,
        TPC_CRC_RUN  = 2'b01,
        TPC_CRC_HOLD = 2'b10
    } tpc_crc_e;
endpackage : tpc_pkg

// ---- tpc_regs.svh ----
// Constants for the thermal, parity and checksum supervisor
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// Event status bit positions
`define TPC_EV_WARM       0
`define TPC_EV_HOT        1
`define TPC_EV_SSC        2
`define TPC_EV_PAR        3
`define TPC_EV_CRC        4
`define TPC_EV_W          5
`define TPC_EV_NONE       5'h00
`define TPC_IRQ_FIXED     4'hF

// Serial frame layout: flags, payload, parity in the last bit
`define TPC_FRAME_W       32
`define TPC_PAYLOAD_W     30
`define TPC_BITCNT_LAST   5'h1F
`define TPC_BITCNT_ZERO   5'h00

// Wetting current codes and channel count
`define TPC_NCH           24
`define TPC_WC_W          3
`define TPC_WC_OFF        3'h0
`define TPC_WC_2MA        3'h2
`define TPC_WC_10MA       3'h4
`define TPC_WC_15MA       3'h5

// Checksum engine
`define TPC_CRC_W         16
`define TPC_CRC_POLY      16'h1021
`define TPC_CRC_SEED      16'hFFFF
`define TPC_CRC_XOROUT    16'h0000
`define TPC_CFG_FIRST     8'h1A
`define TPC_CFG_LAST      8'h24
`define TPC_CFG_W         16
`define TPC_CFG_BITS      176
`define TPC_CRC_IDX_W     8
`define TPC_CRC_IDX_ZERO  8'h00
`define TPC_CRC_IDX_LAST  8'hAF
`define TPC_CRC_TRIG_IDX  161
`define TPC_CFG_KEEP_MASK {176{1'b1}}

`endif

// ---- tpc_supervisor.sv ----
// Thermal event, frame parity and configuration checksum supervisor
`timescale 1ns/1ps
`include "tpc_regs.svh"

// Behaviour
// - Crossing warning trip sets warm_event, pulls interrupt, raises thermal flag in frames.
// - warm_status reads one while the warning condition lasts.
// - During warning with derating on, 10 or 15 mA inputs drop to 2 mA.
// - Reduced current holds until temperature falls below warning release level.
// - Interrupt and event status clear at chip-select rise if status was read.
// - No further interrupts while temperature stays above the same release level.
// - Either derate-off bit keeps full current yet still flags the warning.
// - Leaving warning sets warm_event, pulls interrupt, clears warm_status, resumes settings.
// - Shutdown opens every current source and sink switch.
// - Entering shutdown sets overheat_event, pulls interrupt, raises thermal flag.
// - overheat_status reads one during shutdown, warm_status stays one too.
// - Serial port and configuration stay intact throughout shutdown.
// - Shutdown holds until temperature falls below shutdown release level.
// - Leaving shutdown sets overheat_event, pulls interrupt, keeps warning derating if warm.
// - After shutdown, polling restarts; first cycle end flags switch change, stores defaults.
// - Transmitted frames carry a parity bit making the one count odd.
// - Received frames with even one count are dropped and flagged with interrupt.
// - Checksum is CRC-16 with polynomial 1021h, preset FFFFh.
// - Checksum covers registers 1Ah to 24h in order, reserved bits as zero; the all-ones keep mask passes them unchanged.
// - Trigger starts checksum; completion stores result, flags, interrupts, self-clears trigger.
// - Clearing checksum_done_irq_enable suppresses the completion interrupt.
// - Engine is a 16-stage preset shift register, one shift per bit.
module tpc_supervisor (
    // Core clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_nrst,
    // Serial link pins
    input  wire logic                          i_sclk,
    input  wire logic                          i_cs_n,
    input  wire logic                          i_si,
    output logic                               o_so,
    // Open-drain interrupt pin
    output logic                               o_int_n_o,
    output logic                               o_int_n_oe,
    // Temperature comparator pins
    input  wire logic                          i_temp_warm_trip,
    input  wire logic                          i_temp_warm_hold,
    input  wire logic                          i_temp_hot_trip,
    input  wire logic                          i_temp_hot_hold,
    // Configuration
    input  wire logic                          i_warm_derate_off_source,
    input  wire logic                          i_warm_derate_off_sink,
    input  wire tpc_pkg::tpc_wc_t [23:0]       i_wc_cfg,
    input  wire logic                          i_checksum_trigger,
    input  wire logic                          i_checksum_done_irq_enable,
    input  wire logic [`TPC_CFG_BITS-1:0]      i_cfg_image,
    // Frame exchange with the command decoder
    input  wire logic                          i_event_read,
    input  wire logic [`TPC_PAYLOAD_W-1:0]     i_tx_payload,
    output logic [`TPC_FRAME_W-1:0]            o_rx_word,
    output logic                               o_rx_valid,
    // Polling sequencer
    input  wire logic                          i_switch_change,
    input  wire logic                          i_poll_cycle_done,
    output logic                               o_poll_restart,
    output logic                               o_store_default,
    // Status and current control
    output logic [`TPC_EV_W-1:0]               o_event_status,
    output logic                               o_warm_status,
    output logic                               o_overheat_status,
    output logic                               o_thermal_spi_flag,
    output tpc_pkg::tpc_wc_t [23:0]            o_wc_eff,
    output logic                               o_sources_open,
    output logic [`TPC_CRC_W-1:0]              o_checksum_result,
    output logic                               o_checksum_trigger_clr,
    output logic                               o_checksum_busy
);
    import tpc_pkg::*;

    // One CRC step, shift left with feedback into the three taps
    function automatic logic [`TPC_CRC_W-1:0] crc_step(input logic [`TPC_CRC_W-1:0] c,
                                                      input logic d);
        logic fb;
        fb = c[`TPC_CRC_W-1] ^ d;
        crc_step = {c[`TPC_CRC_W-2:0], 1'b0} ^ (fb ? `TPC_CRC_POLY : 16'h0000);
    endfunction : crc_step

    // Derated current code for one channel
    function automatic tpc_wc_t derate(input tpc_wc_t w);
        derate = (w == `TPC_WC_10MA || w == `TPC_WC_15MA) ? `TPC_WC_2MA : w;
    endfunction : derate

    // Reset release through two flops
    logic rst_s1_r, rst_n;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // ---------------- Link clock domain ----------------
    logic                     frame_rst;
    logic [`TPC_FRAME_W-1:0]  sh_r, txsh_r, tx_word_r, rx_hold_r;
    logic [4:0]               cnt_r;
    logic                     rx_tog_r;
    logic [`TPC_FRAME_W-1:0]  sh_nxt, txsh_nxt, rx_hold_nxt;
    logic [4:0]               cnt_nxt;
    logic                     rx_tog_nxt;

    // Bit counter restarts whenever chip select is high
    assign frame_rst = i_cs_n | ~rst_n;

    // Shift next values; the held word and toggle carry to the core
    always_comb begin
        sh_nxt      = {sh_r[`TPC_FRAME_W-2:0], i_si};
        cnt_nxt     = cnt_r + 5'h01;
        txsh_nxt    = (cnt_r == `TPC_BITCNT_ZERO) ? {tx_word_r[`TPC_FRAME_W-2:0], 1'b0}
                                                  : {txsh_r[`TPC_FRAME_W-2:0], 1'b0};
        rx_hold_nxt = rx_hold_r;
        rx_tog_nxt  = rx_tog_r;
        if (cnt_r == `TPC_BITCNT_LAST) begin
            rx_hold_nxt = sh_nxt;
            rx_tog_nxt  = ~rx_tog_r;
        end
    end

    always_ff @(posedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            sh_r   <= '0;
            txsh_r <= '0;
            cnt_r  <= `TPC_BITCNT_ZERO;
        end else begin
            sh_r   <= sh_nxt;
            txsh_r <= txsh_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    // Held word and toggle must survive between frames
    always_ff @(posedge i_sclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_hold_r <= '0;
            rx_tog_r  <= 1'b0;
        end else begin
            rx_hold_r <= rx_hold_nxt;
            rx_tog_r  <= rx_tog_nxt;
        end
    end

    // First bit comes straight from the core word, then from the shifter
    assign o_so = (cnt_r == `TPC_BITCNT_ZERO) ? tx_word_r[`TPC_FRAME_W-1]
                                              : txsh_r[`TPC_FRAME_W-1];

    // ---------------- Core domain ----------------
    logic [5:0] pin_s1_r, pin_s2_r;
    logic       tog_d_r;
    logic       warm_trip, warm_hold, hot_trip, hot_hold, cs_s, tog_s;
    assign {warm_trip, warm_hold, hot_trip, hot_hold, cs_s, tog_s} = pin_s2_r;

    // Two-flop synchronisers for pins and the frame toggle
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= 6'h02;
            pin_s2_r <= 6'h02;
            tog_d_r  <= 1'b0;
        end else begin
            pin_s1_r <= {i_temp_warm_trip, i_temp_warm_hold, i_temp_hot_trip,
                         i_temp_hot_hold, i_cs_n, rx_tog_r};
            pin_s2_r <= pin_s1_r;
            tog_d_r  <= tog_s;
        end
    end

    logic                    cs_d_r, warm_r, hot_r, int_r, rd_seen_r, pend_r;
    logic                    cs_d_nxt, warm_nxt, hot_nxt, int_nxt, rd_seen_nxt, pend_nxt;
    logic [`TPC_EV_W-1:0]    ev_r, ev_nxt, ev_set, irq_mask;
    logic                    rx_ev, cs_rise, clr, crc_done;
    logic                    restart_nxt, store_nxt, rx_valid_nxt, tflag_nxt;
    logic [`TPC_FRAME_W-1:0] rx_word_nxt, tx_word_nxt;
    tpc_wc_t [23:0]          wc_nxt;

    assign rx_ev   = tog_s ^ tog_d_r;
    assign cs_rise = cs_s & ~cs_d_r;
    assign clr     = cs_rise & rd_seen_r;

    // Thermal states, event flags, interrupt and frame handling
    always_comb begin
        cs_d_nxt = cs_s;
        hot_nxt  = hot_r ? hot_hold : hot_trip;
        warm_nxt = warm_r ? (warm_hold | hot_nxt) : (warm_trip | hot_nxt);
        ev_set   = `TPC_EV_NONE;
        ev_set[`TPC_EV_WARM] = warm_nxt ^ warm_r;
        ev_set[`TPC_EV_HOT]  = hot_nxt ^ hot_r;
        ev_set[`TPC_EV_SSC]  = i_switch_change | (pend_r & i_poll_cycle_done);
        ev_set[`TPC_EV_PAR]  = rx_ev & ~(^rx_hold_r);
        ev_set[`TPC_EV_CRC]  = crc_done;
        irq_mask = {i_checksum_done_irq_enable, `TPC_IRQ_FIXED};
        // Set wins over a clear landing in the same cycle
        ev_nxt   = (ev_r & ~{`TPC_EV_W{clr}}) | ev_set;
        int_nxt  = (int_r & ~clr) | (|(ev_set & irq_mask));
        rd_seen_nxt = cs_rise ? 1'b0 : (rd_seen_r | i_event_read);
        pend_nxt    = (hot_r & ~hot_nxt) | (pend_r & ~i_poll_cycle_done);
        restart_nxt = hot_r & ~hot_nxt;
        store_nxt   = pend_r & i_poll_cycle_done;
        // Bad frames never reach the decoder
        rx_valid_nxt = rx_ev & (^rx_hold_r);
        rx_word_nxt  = rx_valid_nxt ? rx_hold_r : o_rx_word;
        tflag_nxt    = ev_nxt[`TPC_EV_WARM] | ev_nxt[`TPC_EV_HOT];
        // Word only reloads while idle, so it stays still across a frame
        tx_word_nxt = tx_word_r;
        if (cs_s) begin
            tx_word_nxt[`TPC_FRAME_W-1:1] = {tflag_nxt, ev_nxt[`TPC_EV_PAR],
                                             i_tx_payload[`TPC_PAYLOAD_W-2:0]}; // Top bit has no slot
            tx_word_nxt[0] = ~(^tx_word_nxt[`TPC_FRAME_W-1:1]);
        end
        // Current control; shutdown beats warning beats normal
        for (int i = 0; i < `TPC_NCH; i++) begin
            if (hot_nxt)
                wc_nxt[i] = `TPC_WC_OFF;
            else if (warm_nxt && !i_warm_derate_off_source && !i_warm_derate_off_sink)
                wc_nxt[i] = derate(i_wc_cfg[i]);
            else
                wc_nxt[i] = i_wc_cfg[i];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_d_r             <= 1'b1;
            warm_r             <= 1'b0;
            hot_r              <= 1'b0;
            int_r              <= 1'b0;
            rd_seen_r          <= 1'b0;
            pend_r             <= 1'b0;
            ev_r               <= `TPC_EV_NONE;
            o_poll_restart     <= 1'b0;
            o_store_default    <= 1'b0;
            o_rx_valid         <= 1'b0;
            o_rx_word          <= '0;
            tx_word_r          <= 32'h00000001;
            o_thermal_spi_flag <= 1'b0;
            o_wc_eff           <= '0;
        end else begin
            cs_d_r             <= cs_d_nxt;
            warm_r             <= warm_nxt;
            hot_r              <= hot_nxt;
            int_r              <= int_nxt;
            rd_seen_r          <= rd_seen_nxt;
            pend_r             <= pend_nxt;
            ev_r               <= ev_nxt;
            o_poll_restart     <= restart_nxt;
            o_store_default    <= store_nxt;
            o_rx_valid         <= rx_valid_nxt;
            o_rx_word          <= rx_word_nxt;
            tx_word_r          <= tx_word_nxt;
            o_thermal_spi_flag <= tflag_nxt;
            o_wc_eff           <= wc_nxt;
        end
    end

    // Status outputs; registers are untouched by shutdown
    assign o_event_status    = ev_r;
    assign o_warm_status     = warm_r;
    assign o_overheat_status = hot_r;
    assign o_sources_open    = hot_r;
    assign o_int_n_o         = 1'b0;
    assign o_int_n_oe        = int_r;

    // ---------------- Checksum engine ----------------
    tpc_crc_e                  crc_st_r, crc_st_nxt;
    logic [`TPC_CRC_W-1:0]     crc_r, crc_nxt, res_nxt, crc_stepped;
    logic [`TPC_CRC_IDX_W-1:0] idx_r, idx_nxt;
    logic [`TPC_CFG_BITS-1:0]  feed;
    logic                      clr_nxt;

    // Keep mask is all ones so no bits are forced low; trigger bit forced high
    always_comb begin
        feed = i_cfg_image & `TPC_CFG_KEEP_MASK;
        feed[`TPC_CRC_TRIG_IDX] = 1'b1;
    end

    // First register's top bit goes in first; host keeps config still
    assign crc_stepped = crc_step(crc_r, feed[`TPC_CFG_BITS - 1 - int'(idx_r)]);
    assign crc_done    = (crc_st_r == TPC_CRC_RUN) && (idx_r == `TPC_CRC_IDX_LAST);

    always_comb begin
        crc_st_nxt = crc_st_r;
        crc_nxt    = crc_r;
        idx_nxt    = idx_r;
        res_nxt    = o_checksum_result;
        clr_nxt    = 1'b0;
        case (crc_st_r)
            TPC_CRC_IDLE: begin
                if (i_checksum_trigger) begin
                    crc_nxt    = `TPC_CRC_SEED;
                    idx_nxt    = `TPC_CRC_IDX_ZERO;
                    crc_st_nxt = TPC_CRC_RUN;
                end
            end
            TPC_CRC_RUN: begin
                crc_nxt = crc_stepped;
                idx_nxt = idx_r + 8'h01;
                if (crc_done) begin
                    res_nxt    = crc_stepped ^ `TPC_CRC_XOROUT;
                    clr_nxt    = 1'b1;
                    crc_st_nxt = TPC_CRC_HOLD;
                end
            end
            // Wait for the trigger to drop so one request runs once
            TPC_CRC_HOLD: begin
                if (!i_checksum_trigger)
                    crc_st_nxt = TPC_CRC_IDLE;
            end
            default: crc_st_nxt = TPC_CRC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_st_r               <= TPC_CRC_IDLE;
            crc_r                  <= `TPC_CRC_SEED;
            idx_r                  <= `TPC_CRC_IDX_ZERO;
            o_checksum_result      <= 16'h0000;
            o_checksum_trigger_clr <= 1'b0;
        end else begin
            crc_st_r               <= crc_st_nxt;
            crc_r                  <= crc_nxt;
            idx_r                  <= idx_nxt;
            o_checksum_result      <= res_nxt;
            o_checksum_trigger_clr <= clr_nxt;
        end
    end

    assign o_checksum_busy = (crc_st_r == TPC_CRC_RUN);

    // ---------------- Checks ----------------
    a_warm_entry_flag: assert property (@(posedge i_clk) disable iff (!rst_n)
        $rose(warm_r) |-> ev_r[`TPC_EV_WARM] && int_r ##1 o_thermal_spi_flag)
        else $error("warning entry did not flag");
    a_warm_exit_flag: assert property (@(posedge i_clk) disable iff (!rst_n)
        $fell(warm_r) |-> ev_r[`TPC_EV_WARM] && int_r && !o_warm_status)
        else $error("warning exit did not flag");
    a_derate_ch0: assert property (@(posedge i_clk) disable iff (!rst_n)
        $past(warm_nxt && !hot_nxt && !i_warm_derate_off_source && !i_warm_derate_off_sink
              && i_wc_cfg[0] == `TPC_WC_15MA) |-> o_wc_eff[0] == `TPC_WC_2MA)
        else $error("warning current not derated");
    a_hot_all_off: assert property (@(posedge i_clk) disable iff (!rst_n)
        hot_r |-> o_wc_eff == '0 && warm_r)
        else $error("shutdown left current on");
    a_clear_on_cs: assert property (@(posedge i_clk) disable iff (!rst_n)
        (clr && ev_set == `TPC_EV_NONE) |=> !int_r && ev_r == `TPC_EV_NONE)
        else $error("status not cleared after read");
    a_parity_drop: assert property (@(posedge i_clk) disable iff (!rst_n)
        (rx_ev && !(^rx_hold_r)) |=> ev_r[`TPC_EV_PAR] && int_r && !o_rx_valid)
        else $error("bad frame not flagged");
    a_tx_odd: assert property (@(posedge i_clk) disable iff (!rst_n)
        $fell(cs_s) |-> (^tx_word_r) ##1 $stable(tx_word_r))
        else $error("frame parity not odd");
    a_crc_preset: assert property (@(posedge i_clk) disable iff (!rst_n)
        $rose(o_checksum_busy) |-> crc_r == `TPC_CRC_SEED && idx_r == `TPC_CRC_IDX_ZERO)
        else $error("checksum preset wrong");
    a_crc_finish: assert property (@(posedge i_clk) disable iff (!rst_n)
        $rose(o_checksum_busy) |-> ##176 o_checksum_trigger_clr && ev_r[`TPC_EV_CRC])
        else $error("checksum did not finish in 176 cycles");
    a_restart_ssc: assert property (@(posedge i_clk) disable iff (!rst_n)
        (pend_r && i_poll_cycle_done) |=> o_store_default && ev_r[`TPC_EV_SSC] && !pend_r)
        else $error("first cycle after shutdown not flagged");

endmodule : tpc_supervisor
